// ---- verilog/sscs_speed_select.v ----
// speed command selector of a servo drive in speed control mode, with an
// axi4-lite register slave, terminal mapping and analog scaling
// assumes analog samples come from adc logic on clk_sys, pins are asynchronous
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sscs_consts.vh"

module sscs_speed_select (
    input  wire               clk_sys,
    input  wire               sys_rst,
    input  wire [7:0]         s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output wire [1:0]         s_axi_bresp,
    output wire               s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [7:0]         s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output wire [31:0]        s_axi_rdata,
    output wire [1:0]         s_axi_rresp,
    output wire               s_axi_rvalid,
    input  wire               s_axi_rready,
    input  wire [7:0]         programmable_inputs,
    output wire [3:0]         programmable_outputs,
    input  wire signed [15:0] analog_input_first,
    input  wire signed [15:0] analog_input_second,
    output wire signed [17:0] speed_command,
    output wire               speed_limited
);

    // register file
    reg        [15:0] control_mode_select_q;
    reg signed [15:0] preset_speed_one_q;
    reg signed [15:0] preset_speed_two_q;
    reg signed [15:0] preset_speed_three_q;
    reg        [15:0] analog_source_select_q;
    reg        [15:0] analog_full_scale_speed_q;
    reg        [15:0] motor_max_speed_q;
    reg        [15:0] input_map_q;
    reg        [15:0] output_map_q;
    reg signed [15:0] offset_first_q;
    reg signed [15:0] offset_second_q;

    // bus state
    reg        [7:0]  aw_addr_q;
    reg               aw_full_q;
    reg        [31:0] w_data_q;
    reg        [3:0]  w_strb_q;
    reg               w_full_q;
    reg               bvalid_q;
    reg        [1:0]  bresp_q;
    reg               rvalid_q;
    reg        [31:0] rdata_q;
    reg        [1:0]  rresp_q;

    // datapath state
    reg signed [17:0] speed_q;
    reg               limited_q;
    reg        [3:0]  dout_q;

    wire [7:0] di_f;
    wire       do_write;
    wire [15:0] wr16;

    // terminal inputs pass the agreement synchroniser
    sscs_pin_sync #(
        .WIDTH  (8)
    ) u_di_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (programmable_inputs),
        .pin_out (di_f)
    );

    // write address and data are held independently, so either may come first
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready  = !w_full_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign do_write      = aw_full_q && w_full_q;

    // only byte lanes 0 and 1 carry register bits
    assign wr16 = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                   w_strb_q[0] ? w_data_q[7:0]  : 8'h00};

    function [15:0] merge16;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
                       strb[0] ? new_v[7:0]  : old_v[7:0]};
        end
    endfunction

    // presets saturate at the documented range instead of wrapping
    function [15:0] sat_preset;
        input [15:0] v;
        begin
            if (!v[15] && (v > `SSCS_PRESET_LIMIT)) begin
                sat_preset = `SSCS_PRESET_LIMIT;
            end else if (v[15] && ((~v + 16'h0001) > `SSCS_PRESET_LIMIT)) begin
                sat_preset = ~`SSCS_PRESET_LIMIT + 16'h0001;
            end else begin
                sat_preset = v;
            end
        end
    endfunction

    function [15:0] sat_afs;
        input [15:0] v;
        begin
            if (v < `SSCS_AFS_MIN) begin
                sat_afs = `SSCS_AFS_MIN;
            end else if (v > `SSCS_AFS_MAX) begin
                sat_afs = `SSCS_AFS_MAX;
            end else begin
                sat_afs = v;
            end
        end
    endfunction

    // write channel: accept, then commit both halves and answer one cycle later
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_addr_q                 <= 8'h00;
            aw_full_q                 <= 1'b0;
            w_data_q                  <= 32'h0000_0000;
            w_strb_q                  <= 4'h0;
            w_full_q                  <= 1'b0;
            bvalid_q                  <= 1'b0;
            bresp_q                   <= `SSCS_RESP_OKAY;
            control_mode_select_q     <= `SSCS_RST_MODE;
            preset_speed_one_q        <= `SSCS_RST_PRESET1;
            preset_speed_two_q        <= `SSCS_RST_PRESET2;
            preset_speed_three_q      <= `SSCS_RST_PRESET3;
            analog_source_select_q    <= `SSCS_RST_ASRC;
            analog_full_scale_speed_q <= `SSCS_RST_AFS;
            motor_max_speed_q         <= `SSCS_RST_MOTOR_MAX;
            input_map_q               <= `SSCS_RST_IN_MAP;
            output_map_q              <= `SSCS_RST_OUT_MAP;
            offset_first_q            <= 16'h0000;
            offset_second_q           <= 16'h0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
            end
            if (s_axi_bready && bvalid_q) begin
                bvalid_q <= 1'b0;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= `SSCS_RESP_OKAY;
                case (aw_addr_q)
                    `SSCS_OFS_MODE: begin
                        control_mode_select_q <= merge16(control_mode_select_q, wr16,
                                                         w_strb_q[1:0]);
                    end
                    `SSCS_OFS_PRESET1: begin
                        preset_speed_one_q <= sat_preset(merge16(preset_speed_one_q,
                                                         wr16, w_strb_q[1:0]));
                    end
                    `SSCS_OFS_PRESET2: begin
                        preset_speed_two_q <= sat_preset(merge16(preset_speed_two_q,
                                                         wr16, w_strb_q[1:0]));
                    end
                    `SSCS_OFS_PRESET3: begin
                        preset_speed_three_q <= sat_preset(merge16(preset_speed_three_q,
                                                           wr16, w_strb_q[1:0]));
                    end
                    `SSCS_OFS_ASRC: begin
                        analog_source_select_q <= merge16(analog_source_select_q, wr16,
                                                          w_strb_q[1:0]);
                    end
                    `SSCS_OFS_AFS: begin
                        analog_full_scale_speed_q <= sat_afs(merge16(analog_full_scale_speed_q,
                                                             wr16, w_strb_q[1:0]));
                    end
                    `SSCS_OFS_MOTOR_MAX: begin
                        motor_max_speed_q <= merge16(motor_max_speed_q, wr16, w_strb_q[1:0]);
                    end
                    `SSCS_OFS_IN_MAP: begin
                        input_map_q <= merge16(input_map_q, wr16, w_strb_q[1:0]);
                    end
                    `SSCS_OFS_OUT_MAP: begin
                        output_map_q <= merge16(output_map_q, wr16, w_strb_q[1:0]);
                    end
                    `SSCS_OFS_ZERO_SET: begin
                        // capture the raw sample as the drift to subtract from now on
                        if (wr16[0]) begin
                            offset_first_q <= analog_input_first;
                        end
                        if (wr16[1]) begin
                            offset_second_q <= analog_input_second;
                        end
                    end
                    `SSCS_OFS_OFFSET1, `SSCS_OFS_OFFSET2, `SSCS_OFS_SPEED,
                    `SSCS_OFS_STATUS: begin
                        bresp_q <= `SSCS_RESP_OKAY; // read-only, write ignored
                    end
                    default: begin
                        bresp_q <= `SSCS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // function inputs picked from the filtered terminals by the input map
    wire sel_a   = di_f[input_map_q[2:0]];
    wire sel_b   = di_f[input_map_q[6:4]];
    wire sel_dir = di_f[input_map_q[10:8]];

    wire mode_reg    = (control_mode_select_q == `SSCS_MODE_REGISTER);
    wire mode_analog = (control_mode_select_q == `SSCS_MODE_ANALOG);

    // preset decode: zero when both selects are off
    reg signed [15:0] preset_sel;
    always @* begin
        case ({sel_a, sel_b})
            2'b01:   preset_sel = preset_speed_one_q;
            2'b10:   preset_sel = preset_speed_two_q;
            2'b11:   preset_sel = preset_speed_three_q;
            default: preset_sel = 16'h0000;
        endcase
    end

    wire signed [17:0] preset_ext = {{2{preset_sel[15]}}, preset_sel};
    wire signed [17:0] preset_cmd = sel_dir ? -preset_ext : preset_ext;

    // analog path: subtract drift, clip to +-2^15, scale by full scale
    wire signed [15:0] ain    = analog_source_select_q[0] ? analog_input_second
                                                          : analog_input_first;
    wire signed [15:0] ain_of = analog_source_select_q[0] ? offset_second_q
                                                          : offset_first_q;
    wire signed [16:0] ain_diff = {ain[15], ain} - {ain_of[15], ain_of};
    reg  signed [16:0] ain_clip;
    always @* begin
        if (!ain_diff[16] && (ain_diff > $signed(`SSCS_ADC_POS_LIMIT))) begin
            ain_clip = `SSCS_ADC_POS_LIMIT;
        end else if (ain_diff[16] && (ain_diff < $signed(`SSCS_ADC_NEG_LIMIT))) begin
            ain_clip = `SSCS_ADC_NEG_LIMIT;
        end else begin
            ain_clip = ain_diff;
        end
    end

    // full scale is r/min, command is 0.1 r/min, hence the factor ten
    wire [17:0] afs_x10 = {1'b0, analog_full_scale_speed_q, 1'b0} +
                          {analog_full_scale_speed_q[14:0], 3'b000};
    wire signed [34:0] ain_prod = ain_clip * $signed({1'b0, afs_x10[16:0]});
    wire signed [17:0] analog_cmd = ain_prod[`SSCS_ADC_SHIFT+17:`SSCS_ADC_SHIFT];

    // source pick; unsupported modes command standstill
    wire signed [17:0] raw_cmd = mode_reg    ? preset_cmd :
                                 mode_analog ? analog_cmd : 18'h0_0000;

    // limit to the motor maximum in either direction
    wire signed [17:0] max_ext = {2'b00, motor_max_speed_q};
    wire               over_p  = raw_cmd > max_ext;
    wire               over_n  = raw_cmd < -max_ext;
    wire signed [17:0] lim_cmd = over_p ? max_ext : (over_n ? -max_ext : raw_cmd);

    // output command is registered so downstream loops see a clean value
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            speed_q   <= 18'h0_0000;
            limited_q <= 1'b0;
        end else begin
            speed_q   <= lim_cmd;
            limited_q <= over_p || over_n;
        end
    end

    assign speed_command = speed_q;
    assign speed_limited = limited_q;

    // output terminals: two-bit source per terminal (off, zero speed, limited, analog)
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_dout
            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    dout_q[k] <= 1'b0;
                end else begin
                    case (output_map_q[2*k+1:2*k])
                        2'b01:   dout_q[k] <= (speed_q == 18'h0_0000);
                        2'b10:   dout_q[k] <= limited_q;
                        2'b11:   dout_q[k] <= mode_analog;
                        default: dout_q[k] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    assign programmable_outputs = dout_q;

    // read channel: data registered, answer one cycle after the address is taken
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `SSCS_RESP_OKAY;
        end else begin
            if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
            if (s_axi_arvalid && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rresp_q  <= `SSCS_RESP_OKAY;
                case (s_axi_araddr)
                    `SSCS_OFS_MODE:      rdata_q <= {16'h0000, control_mode_select_q};
                    `SSCS_OFS_PRESET1:   rdata_q <= {16'h0000, preset_speed_one_q};
                    `SSCS_OFS_PRESET2:   rdata_q <= {16'h0000, preset_speed_two_q};
                    `SSCS_OFS_PRESET3:   rdata_q <= {16'h0000, preset_speed_three_q};
                    `SSCS_OFS_ASRC:      rdata_q <= {16'h0000, analog_source_select_q};
                    `SSCS_OFS_AFS:       rdata_q <= {16'h0000, analog_full_scale_speed_q};
                    `SSCS_OFS_MOTOR_MAX: rdata_q <= {16'h0000, motor_max_speed_q};
                    `SSCS_OFS_IN_MAP:    rdata_q <= {16'h0000, input_map_q};
                    `SSCS_OFS_OUT_MAP:   rdata_q <= {16'h0000, output_map_q};
                    `SSCS_OFS_ZERO_SET:  rdata_q <= 32'h0000_0000;
                    `SSCS_OFS_OFFSET1:   rdata_q <= {16'h0000, offset_first_q};
                    `SSCS_OFS_OFFSET2:   rdata_q <= {16'h0000, offset_second_q};
                    `SSCS_OFS_SPEED:     rdata_q <= {14'h0000, speed_q};
                    `SSCS_OFS_STATUS: begin
                        rdata_q <= {14'h0000, dout_q, limited_q, mode_analog,
                                    sel_dir, sel_b, sel_a, 1'b0, di_f};
                    end
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= `SSCS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ---- include/sscs_consts.vh ----
// constants for the servo speed command selector: register byte offsets,
// reset values, limits and mode codes
// assumes inclusion by bare name from the speed selector and its testbench; the pin synchroniser does not include it
`ifndef SSCS_CONSTS_VH
`define SSCS_CONSTS_VH

// register byte offsets on the axi4-lite slave
`define SSCS_OFS_MODE        8'h00
`define SSCS_OFS_PRESET1     8'h04
`define SSCS_OFS_PRESET2     8'h08
`define SSCS_OFS_PRESET3     8'h0c
`define SSCS_OFS_ASRC        8'h10
`define SSCS_OFS_AFS         8'h14
`define SSCS_OFS_MOTOR_MAX   8'h18
`define SSCS_OFS_IN_MAP      8'h1c
`define SSCS_OFS_OUT_MAP     8'h20
`define SSCS_OFS_ZERO_SET    8'h24
`define SSCS_OFS_OFFSET1     8'h28
`define SSCS_OFS_OFFSET2     8'h2c
`define SSCS_OFS_SPEED       8'h30
`define SSCS_OFS_STATUS      8'h34

// control mode codes
`define SSCS_MODE_REGISTER   16'h0000
`define SSCS_MODE_ANALOG     16'h0003

// reset values
`define SSCS_RST_MODE        16'h0000
`define SSCS_RST_PRESET1     16'h03e8
`define SSCS_RST_PRESET2     16'h07d0
`define SSCS_RST_PRESET3     16'h0bb8
`define SSCS_RST_ASRC        16'h0000
`define SSCS_RST_AFS         16'h0bb8
`define SSCS_RST_MOTOR_MAX   16'h7530
`define SSCS_RST_IN_MAP      16'h0210
`define SSCS_RST_OUT_MAP     16'h0000

// limits: presets in 0.1 r/min, full scale in r/min
`define SSCS_PRESET_LIMIT    16'h7d00
`define SSCS_AFS_MIN         16'h0001
`define SSCS_AFS_MAX         16'h2710

// analog scaling: a sample of 2^15 counts stands for 10 V
`define SSCS_ADC_SHIFT       15
`define SSCS_ADC_POS_LIMIT   17'h0_8000
`define SSCS_ADC_NEG_LIMIT   17'h1_8000

// axi response codes
`define SSCS_RESP_OKAY       2'b00
`define SSCS_RESP_SLVERR     2'b10

`endif

// ---- verilog/sscs_pin_sync.v ----
// three-stage synchroniser for pin inputs, one lane per bit
// assumes asynchronous pins; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module sscs_pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            // first stage feeds only the second, to keep metastability contained
            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    out_q <= 1'b0;
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign pin_out[i] = out_q;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- tb/sscs_speed_select_assertions.sv ----
// checker on the speed selector's bus handshake and speed output
// assumes the motor maximum stays at its reset value of 30000
`timescale 1ns/1ps
`default_nettype none

module sscs_sel_chk (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic signed [17:0] speed_command,
    input wire logic               speed_limited
);
    localparam logic signed [17:0] max_spd = 18'h0_7530;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // read side: answer one cycle after the address, gone once taken
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("address taken while busy");
    // write side: response two edges after both halves, no new request meanwhile
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while busy");
    // the clamp flag only ever stands beside a command at the motor maximum
    property p_lim; speed_limited |-> speed_command == max_spd || speed_command == -max_spd;
    endproperty
    a_lim: assert property (p_lim) else $error("limited flag without clamp");
    property p_range; speed_command <= max_spd && speed_command >= -max_spd; endproperty
    a_range: assert property (p_range) else $error("command beyond motor maximum");
    c_lim: cover property (speed_limited);
    c_neg: cover property (speed_command < 0);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind sscs_speed_select sscs_sel_chk i_sscs_sel_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .speed_command(speed_command), .speed_limited(speed_limited)
);
`default_nettype wire

// ---- tb/sscs_host_model.sv ----
// host controller model: drives the terminal pins and the adc samples
// assumes the bench sets wanted levels; select terminals are DI1..DI3
`timescale 1ns/1ps
`default_nettype none

module sscs_host_model (
    input  wire logic               clk_sys,
    input  wire logic               speed_select_a,
    input  wire logic               speed_select_b,
    input  wire logic               speed_direction_input,
    input  wire logic signed [15:0] v1,
    input  wire logic signed [15:0] v2,
    output logic        [7:0]       programmable_inputs = 8'h00,
    output logic signed [15:0]      analog_input_first = 16'h0000,
    output logic signed [15:0]      analog_input_second = 16'h0000
);
    logic [4:0] junk_q = 5'h00;
    // unused terminals toggle, so a wrong terminal map cannot hide
    always @(posedge clk_sys) begin
        junk_q              <= junk_q + 5'h01;
        programmable_inputs <= {junk_q, speed_direction_input, speed_select_b, speed_select_a};
        analog_input_first  <= v1;
        analog_input_second <= v2;
    end
endmodule
`default_nettype wire

// ---- tb/sscs_testbench.sv ----
// bench for the speed selector: bus tasks, one task per scenario
// assumes the host model drives pins and samples; motor max stays at reset
`timescale 1ns/1ps
`default_nettype none
`include "sscs_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
$display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end

module testbench;
    logic               clk_sys = 1'b0;
    logic               sys_rst = 1'b1;
    logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]        wdata = 32'h0000_0000, rd;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic               rready = 1'b0, speed_select_a = 1'b0, speed_select_b = 1'b0;
    logic               speed_direction_input = 1'b0;
    logic signed [15:0] v1 = 16'h0000, v2 = 16'h0000;
    logic [1:0]         rsp;
    wire                awready, wready, bvalid, arready, rvalid, limited;
    wire [1:0]          bresp, rresp;
    wire [31:0]         rdata;
    wire [3:0]          douts;
    wire [7:0]          dins;
    wire signed [15:0]  ai1, ai2;
    wire signed [17:0]  spd;
    int                 checks = 0, miscompares = 0;

    sscs_speed_select i_sscs_speed_select (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .programmable_inputs(dins), .programmable_outputs(douts),
        .analog_input_first(ai1), .analog_input_second(ai2),
        .speed_command(spd), .speed_limited(limited)
    );
    sscs_host_model i_sscs_host_model (
        .clk_sys(clk_sys), .speed_select_a(speed_select_a), .speed_select_b(speed_select_b),
        .speed_direction_input(speed_direction_input), .v1(v1), .v2(v2),
        .programmable_inputs(dins), .analog_input_first(ai1), .analog_input_second(ai2)
    );

    // free-running system clock
    initial forever #5 clk_sys = ~clk_sys;

    // each half is dropped when taken; bready stays up until the response
    task automatic wr(input [7:0] a, input [15:0] d, output [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {16'h0000, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input [7:0] a, output [31:0] d, output [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask

    // pins need several edges through the synchroniser, so wait before judging
    task automatic spd_is(input logic signed [17:0] e);
        repeat (8) @(posedge clk_sys);
        `CHK(spd, e)
    endtask

    task automatic t_reset;
        logic [7:0]  ofs [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h00};
        logic [15:0] ev [5] = '{16'h03e8, 16'h07d0, 16'h0bb8, 16'h0000, 16'h0000};
        for (int i = 0; i < 5; i++) begin
            rdr(ofs[i], rd, rsp);
            `CHK(rd, {16'h0000, ev[i]})
        end
        $display("reset test done");
    endtask

    task automatic t_select;
        int m;
        wr(`SSCS_OFS_OUT_MAP, 16'h0001, rsp);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            {speed_direction_input, speed_select_a, speed_select_b} <= i[2:0];
            m = 1000 * i[1:0];
            spd_is(18'(i[2] ? -m : m));
            `CHK(douts[0], m == 0)
        end
        $display("select test done");
    endtask

    task automatic t_write;
        @(posedge clk_sys);
        {speed_direction_input, speed_select_a, speed_select_b} <= 3'h5;
        spd_is(18'h3_fc18);
        wr(`SSCS_OFS_PRESET1, 16'hfb2e, rsp);
        repeat (2) @(posedge clk_sys);
        `CHK(spd, 18'h0_04d2)
        wr(`SSCS_OFS_PRESET1, 16'h7fff, rsp);
        rdr(`SSCS_OFS_PRESET1, rd, rsp);
        `CHK(rd, 32'h0000_7d00)
        @(posedge clk_sys);
        speed_direction_input <= 1'b0;
        spd_is(18'h0_7530);
        `CHK(limited, 1'b1)
        $display("write test done");
    endtask

    task automatic t_analog;
        wr(`SSCS_OFS_MODE, 16'h0003, rsp);
        wr(`SSCS_OFS_AFS, 16'h03e8, rsp);
        v1 <= 16'h4000;
        v2 <= 16'hc000;
        spd_is(18'h0_1388);
        wr(`SSCS_OFS_ASRC, 16'h0001, rsp);
        spd_is(18'h3_ec78);
        v2 <= 16'h8000;
        spd_is(18'h3_d8f0);
        wr(`SSCS_OFS_ASRC, 16'h0000, rsp);
        v1 <= 16'h0064;
        repeat (2) @(posedge clk_sys);
        wr(`SSCS_OFS_ZERO_SET, 16'h0001, rsp);
        v1 <= 16'h4064;
        spd_is(18'h0_1388);
        wr(`SSCS_OFS_AFS, 16'h0000, rsp);
        rdr(`SSCS_OFS_AFS, rd, rsp);
        `CHK(rd, 32'h0000_0001)
        $display("analog test done");
    endtask

    task automatic t_unmapped;
        wr(8'h40, 16'h1234, rsp);
        `CHK(rsp, 2'h2)
        rdr(8'h40, rd, rsp);
        `CHK({rsp, rd}, {2'h2, 32'h0000_0000})
        wr(`SSCS_OFS_MODE, 16'h0001, rsp);
        spd_is(18'h0_0000);
        $display("unmapped test done");
    endtask

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_select;
        t_write;
        t_analog;
        t_unmapped;
        end_sim;
    end

    // watchdog: the tests need well under two thousand cycles
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
